// [hdl/ufdr_regs.svh]
`ifndef UFDR_REGS_SVH
`define UFDR_REGS_SVH
// Register byte addresses.
`define UFDR_ADR_DATA 8'h00
`define UFDR_ADR_FCTL 8'h04
`define UFDR_ADR_LSTAT 8'h08
`define UFDR_ADR_IEN 8'h0C
`define UFDR_ADR_IST 8'h10
// fifo_control fields.
`define UFDR_FCTL_EN 0
`define UFDR_FCTL_RXCLR 1
`define UFDR_FCTL_TXCLR 2
`define UFDR_FCTL_DMA 3
`define UFDR_FCTL_TRIG 6
// Interrupt status and mask fields.
`define UFDR_INT_RXTRIG 0
`define UFDR_INT_TXEMPTY 1
`define UFDR_INT_LINE 2
`define UFDR_INT_TOUT 3
// Sizes and levels.
`define UFDR_DEPTH 5'h10
`define UFDR_HOLD 5'h01
`define UFDR_LVL0 5'h01
`define UFDR_LVL1 5'h04
`define UFDR_LVL2 5'h08
`define UFDR_LVL3 5'h0E
// Receive timeout timing.
`define UFDR_CLK_HZ 50000000
`define UFDR_BAUD 115200
`define UFDR_CHAR_BITS 10
`define UFDR_TOUT_CHARS 4
`define UFDR_TOUT_CYCLES \
   ((`UFDR_TOUT_CHARS*`UFDR_CHAR_BITS*`UFDR_CLK_HZ)/`UFDR_BAUD)
`endif

// [hdl/ufdr_pkg.sv]
package ufdr_pkg;
   typedef logic [4:0] ufdr_cnt_t;
   typedef logic [3:0] ufdr_ptr_t;
   typedef struct packed {
      logic brk;
      logic frame_err;
      logic parity_err;
      logic [7:0] data;
   } ufdr_rxchar_s;
endpackage : ufdr_pkg

// [hdl/ufdr_top.sv]
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ufdr_regs.svh"
// Summary of operation
// - FIFOs on and all enables clear: no interrupt; software polls status.
// - Data-ready status bit is one while the receive FIFO holds a byte.
// - Status bits one to four show overrun, parity, framing, break.
// - Status bit five is one while the transmit FIFO is empty.
// - Status bit six needs empty transmit FIFO and empty shifter.
// - Status bit seven is one while any stored character has an error.
// - Control bit three picks DMA mode zero or block mode one.
// - Mode zero: transmit ready low when empty, high once loaded.
// - Mode zero: receive ready low while any received character waits.
// - Mode one: transmit ready high only when the FIFO is full.
// - Mode one: receive ready low at trigger or timeout, high when empty.
// - Transmit event on becoming empty, receive event on reaching trigger.
// - Bits seven and six pick the trigger; FIFO still fills to full.
// - Control bits five and four do nothing and read as zero.
// - Control bit two empties the transmit FIFO and clears itself.
// - Trigger codes zero to three give levels 1, 4, 8 and 14.
// - Other control bits are ignored unless bit zero is written as one.
// - Control bit one empties the receive FIFO and clears itself.
module ufdr_top
   import ufdr_pkg::*;
#(
   parameter int unsigned TOUT_CYCLES = `UFDR_TOUT_CYCLES
) (
   // Clock and reset.
   input logic clk_i,
   input logic rst_i,
   // Wishbone slave.
   input logic cyc_i,
   input logic stb_i,
   input logic we_i,
   input logic [7:0] adr_i,
   input logic [3:0] sel_i,
   input logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Interrupt.
   output logic irq_o,
   // DMA pacing.
   output logic tx_dma_request_n_o,
   output logic rx_dma_request_n_o,
   // Receive shifter side.
   input logic rx_valid_i,
   input ufdr_rxchar_s rx_char_i,
   // Transmit shifter side.
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input logic tx_ready_i,
   input logic tx_shift_empty_i
);

   // ************************************************
   // Bus slave
   // ************************************************
   logic ack_q, req, wr, rd, wr_fctl;
   logic [31:0] dat_q;
   logic [7:0] rmux;

   assign req = cyc_i & stb_i & ~ack_q;
   assign wr = req & we_i & sel_i[0];
   assign rd = req & ~we_i;
   assign wr_fctl = wr && (adr_i == `UFDR_ADR_FCTL);
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // ************************************************
   // FIFO control
   // ************************************************
   logic fifo_en_q, dma_mode_q;
   logic [1:0] trig_sel_q;
   logic en_change, tx_clr, rx_clr, mode1;
   ufdr_cnt_t cap, rx_lvl;

   // Toggling the enable empties both FIFOs so no stale data survives.
   assign en_change = wr_fctl && (dat_i[`UFDR_FCTL_EN] != fifo_en_q);
   assign tx_clr = (wr_fctl & dat_i[`UFDR_FCTL_EN] &
                    dat_i[`UFDR_FCTL_TXCLR]) | en_change;
   assign rx_clr = (wr_fctl & dat_i[`UFDR_FCTL_EN] &
                    dat_i[`UFDR_FCTL_RXCLR]) | en_change;
   assign mode1 = fifo_en_q & dma_mode_q;
   // With FIFOs off each direction holds a single character.
   assign cap = fifo_en_q ? `UFDR_DEPTH : `UFDR_HOLD;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_en_q <= 1'b0;
         dma_mode_q <= 1'b0;
         trig_sel_q <= 2'b00;
      end else if (wr_fctl) begin
         fifo_en_q <= dat_i[`UFDR_FCTL_EN];
         if (dat_i[`UFDR_FCTL_EN]) begin
            dma_mode_q <= dat_i[`UFDR_FCTL_DMA];
            trig_sel_q <= dat_i[`UFDR_FCTL_TRIG +: 2];
         end
      end
   end

   always_comb begin
      case (trig_sel_q)
         2'b00: rx_lvl = `UFDR_LVL0;
         2'b01: rx_lvl = `UFDR_LVL1;
         2'b10: rx_lvl = `UFDR_LVL2;
         default: rx_lvl = `UFDR_LVL3;
      endcase
   end

   // ************************************************
   // Transmit FIFO
   // ************************************************
   logic [7:0] tx_mem_q [16];
   ufdr_ptr_t tx_wp_q, tx_rp_q;
   ufdr_cnt_t tx_cnt_q;
   logic tx_push, tx_pop;

   // A write into a full FIFO is dropped.
   assign tx_push = wr && (adr_i == `UFDR_ADR_DATA) && (tx_cnt_q < cap);
   assign tx_pop = tx_ready_i && (tx_cnt_q != 5'h00);
   assign tx_valid_o = (tx_cnt_q != 5'h00);
   assign tx_data_o = tx_valid_o ? tx_mem_q[tx_rp_q] : 8'h00;

   always_ff @(posedge clk_i) begin
      if (tx_push) begin
         tx_mem_q[tx_wp_q] <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || tx_clr) begin
         tx_wp_q <= 4'h0;
         tx_rp_q <= 4'h0;
         tx_cnt_q <= 5'h00;
      end else begin
         tx_wp_q <= tx_wp_q + {3'h0, tx_push};
         tx_rp_q <= tx_rp_q + {3'h0, tx_pop};
         tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
      end
   end

   // ************************************************
   // Receive FIFO
   // ************************************************
   ufdr_rxchar_s rx_mem_q [16];
   ufdr_ptr_t rx_wp_q;
   ufdr_ptr_t rx_rp_q;
   ufdr_cnt_t rx_cnt_q;
   ufdr_cnt_t rx_cnt_d;
   ufdr_cnt_t rx_ecnt_q;
   ufdr_rxchar_s rx_head;
   logic rx_push;
   logic rx_pop;
   logic rx_over;
   logic in_err;
   logic head_err;

   assign rx_push = rx_valid_i && (rx_cnt_q < cap);
   assign rx_over = rx_valid_i && !(rx_cnt_q < cap);
   assign rx_pop = rd && (adr_i == `UFDR_ADR_DATA) && (rx_cnt_q != 5'h00);
   assign rx_head = rx_mem_q[rx_rp_q];
   assign in_err = rx_char_i.brk | rx_char_i.frame_err |
                   rx_char_i.parity_err;
   assign head_err = rx_head.brk | rx_head.frame_err | rx_head.parity_err;
   assign rx_cnt_d = rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};

   always_ff @(posedge clk_i) begin
      if (rx_push) begin
         rx_mem_q[rx_wp_q] <= rx_char_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_clr) begin
         rx_wp_q <= 4'h0;
         rx_rp_q <= 4'h0;
         rx_cnt_q <= 5'h00;
         rx_ecnt_q <= 5'h00;
      end else begin
         rx_wp_q <= rx_wp_q + {3'h0, rx_push};
         rx_rp_q <= rx_rp_q + {3'h0, rx_pop};
         rx_cnt_q <= rx_cnt_d;
         rx_ecnt_q <= rx_ecnt_q + {4'h0, rx_push & in_err}
                      - {4'h0, rx_pop & head_err};
      end
   end

   // ************************************************
   // Receive timeout
   // ************************************************
   logic [31:0] tout_cnt_q;
   logic tout_q, tout_run, tout_hit, tout_rst;

   // Any receive FIFO push, pop or clear restarts the idle count.
   assign tout_rst = rx_push | rx_pop | rx_clr;
   assign tout_run = (rx_cnt_q != 5'h00) && (rx_cnt_q < rx_lvl) && !tout_q;
   assign tout_hit = tout_run && !tout_rst &&
                     (tout_cnt_q == TOUT_CYCLES - 1);

   always_ff @(posedge clk_i) begin
      if (rst_i || tout_rst || !tout_run) begin
         tout_cnt_q <= 32'h0;
      end else begin
         tout_cnt_q <= tout_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || tout_rst) begin
         tout_q <= 1'b0;
      end else if (tout_hit) begin
         tout_q <= 1'b1;
      end
   end

   // ************************************************
   // DMA ready outputs
   // ************************************************
   logic rx_rdy_q;

   always_ff @(posedge clk_i) begin
      if (rst_i || rx_clr || rx_cnt_q == 5'h00) begin
         rx_rdy_q <= 1'b0;
      end else if (rx_cnt_q >= rx_lvl || tout_q) begin
         rx_rdy_q <= 1'b1;
      end
   end

   assign rx_dma_request_n_o = mode1 ? ~rx_rdy_q :
                               (rx_cnt_q == 5'h00);
   assign tx_dma_request_n_o = mode1 ? (tx_cnt_q == `UFDR_DEPTH) :
                               (tx_cnt_q != 5'h00);

   // ************************************************
   // Line status
   // ************************************************
   logic over_q, rd_lstat;
   logic [7:0] line_status;

   assign rd_lstat = rd && (adr_i == `UFDR_ADR_LSTAT);

   // Overrun is sticky until software reads the status; a new one wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         over_q <= 1'b0;
      end else if (rx_over) begin
         over_q <= 1'b1;
      end else if (rd_lstat) begin
         over_q <= 1'b0;
      end
   end

   always_comb begin
      line_status = 8'h00;
      line_status[0] = (rx_cnt_q != 5'h00);
      line_status[1] = over_q;
      line_status[2] = line_status[0] & rx_head.parity_err;
      line_status[3] = line_status[0] & rx_head.frame_err;
      line_status[4] = line_status[0] & rx_head.brk;
      line_status[5] = (tx_cnt_q == 5'h00);
      line_status[6] = (tx_cnt_q == 5'h00) & tx_shift_empty_i;
      line_status[7] = (rx_ecnt_q != 5'h00);
   end

   // ************************************************
   // Interrupts
   // ************************************************
   logic [3:0] ien_q, ist_q, ev, w1c;

   assign ev[`UFDR_INT_RXTRIG] = rx_push && (rx_cnt_d == rx_lvl);
   assign ev[`UFDR_INT_TXEMPTY] = tx_pop && !tx_push &&
                                  (tx_cnt_q == 5'h01);
   assign ev[`UFDR_INT_LINE] = rx_over | (rx_push & in_err);
   assign ev[`UFDR_INT_TOUT] = tout_hit;
   assign w1c = (wr && adr_i == `UFDR_ADR_IST) ? dat_i[3:0] : 4'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ien_q <= 4'h0;
      end else if (wr && adr_i == `UFDR_ADR_IEN) begin
         ien_q <= dat_i[3:0];
      end
   end

   // A new event in the clearing cycle keeps its bit set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_q <= 4'h0;
      end else begin
         ist_q <= (ist_q & ~w1c) | ev;
      end
   end

   assign irq_o = |(ist_q & ien_q);

   // ************************************************
   // Read data
   // ************************************************
   always_comb begin
      case (adr_i)
         `UFDR_ADR_DATA: rmux = line_status[0] ? rx_head.data : 8'h00;
         `UFDR_ADR_FCTL: rmux = {trig_sel_q, 2'b00, dma_mode_q,
                                 2'b00, fifo_en_q};
         `UFDR_ADR_LSTAT: rmux = line_status;
         `UFDR_ADR_IEN: rmux = {4'h0, ien_q};
         `UFDR_ADR_IST: rmux = {4'h0, ist_q};
         default: rmux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0;
      end else if (rd) begin
         dat_q <= {24'h0, rmux};
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   property p_poll;
      @(posedge clk_i) disable iff (rst_i)
      (ien_q == 4'h0) |-> !irq_o;
   endproperty
   a_poll: assert property (p_poll)
      else $error("interrupt raised with all enables clear");
   property p_ready;
      @(posedge clk_i) disable iff (rst_i)
      (rx_push && !rx_clr) |=> line_status[0];
   endproperty
   a_ready: assert property (p_ready)
      else $error("data ready missing after receive push");
   property p_txmode0;
      @(posedge clk_i) disable iff (rst_i)
      (!mode1 && !wr_fctl && tx_push && !tx_pop) |=> tx_dma_request_n_o;
   endproperty
   a_txmode0: assert property (p_txmode0)
      else $error("transmit ready low after load in mode zero");
   property p_rxmode0;
      @(posedge clk_i) disable iff (rst_i)
      (!mode1 && !wr_fctl && rx_push && !rx_pop) |=> !rx_dma_request_n_o;
   endproperty
   a_rxmode0: assert property (p_rxmode0)
      else $error("receive ready high with data in mode zero");
   // The second cycle only judges a pop that the shifter really made.
   property p_txfull;
      @(posedge clk_i) disable iff (rst_i)
      (mode1 && !wr_fctl && tx_cnt_q == 5'h0F && tx_push && !tx_pop)
      |=> tx_dma_request_n_o ##1
         (!$past(tx_ready_i) || $past(wr_fctl) || !tx_dma_request_n_o);
   endproperty
   a_txfull: assert property (p_txfull)
      else $error("transmit ready wrong at full in block mode");
   property p_rxtrig;
      @(posedge clk_i) disable iff (rst_i)
      (mode1 && !wr_fctl && rx_cnt_q >= rx_lvl) |=> !rx_dma_request_n_o;
   endproperty
   a_rxtrig: assert property (p_rxtrig)
      else $error("receive ready not low at trigger in block mode");
   property p_sticky;
      @(posedge clk_i) disable iff (rst_i)
      ev[`UFDR_INT_TXEMPTY] |=> ist_q[`UFDR_INT_TXEMPTY] &&
                               line_status[5];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("transmit empty event lost");
   property p_txclr;
      @(posedge clk_i) disable iff (rst_i)
      tx_clr |=> !tx_valid_o && line_status[5];
   endproperty
   a_txclr: assert property (p_txclr)
      else $error("transmit FIFO not emptied by clear");
   property p_rxclr;
      @(posedge clk_i) disable iff (rst_i)
      rx_clr |=> !line_status[0] && !line_status[7];
   endproperty
   a_rxclr: assert property (p_rxclr)
      else $error("receive FIFO not emptied by clear");
   property p_ignore;
      @(posedge clk_i) disable iff (rst_i)
      (wr_fctl && !dat_i[`UFDR_FCTL_EN]) |=>
         !fifo_en_q && $stable(dma_mode_q) && $stable(trig_sel_q);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("control bits taken without enable bit");

endmodule : ufdr_top

// [verif/ufdr_shifter_model.sv]
`timescale 1ns/1ps
module ufdr_shifter_model
   import ufdr_pkg::*;
#(
   parameter int BUSY = 12
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Transmit shifter side.
   input wire logic tx_go_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output logic tx_shift_empty_o,
   // Receive shifter side.
   output logic rx_valid_o,
   output ufdr_rxchar_s rx_char_o
);
   logic [7:0] busy_q;
   logic [7:0] got_q[$];

   // The shifter takes a byte, then stays busy so that empty lags.
   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_ready_o <= 1'b0;
         busy_q <= 8'h00;
      end else if (tx_ready_o && tx_valid_i) begin
         tx_ready_o <= 1'b0;
         busy_q <= 8'(BUSY);
         got_q.push_back(tx_data_i);
      end else begin
         tx_ready_o <= tx_go_i && tx_valid_i && busy_q == 8'h00;
         if (busy_q != 8'h00) busy_q <= busy_q - 8'h01;
      end
   end
   assign tx_shift_empty_o = busy_q == 8'h00;

   initial begin
      rx_valid_o = 1'b0;
      rx_char_o = '0;
   end

   // Idle data lines show the inverse of the last character.
   task automatic send(input ufdr_rxchar_s c);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_char_o <= c;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_char_o <= ~c;
   endtask : send
endmodule : ufdr_shifter_model

// [verif/ufdr_top_tb.sv]
`timescale 1ns/1ps
`include "ufdr_regs.svh"
module ufdr_top_tb
   import ufdr_pkg::*;
;
   localparam int TOUT = 40;
   localparam logic [7:0] A_DAT = `UFDR_ADR_DATA;
   localparam logic [7:0] A_FCTL = `UFDR_ADR_FCTL;
   localparam logic [7:0] A_LSTAT = `UFDR_ADR_LSTAT;
   localparam logic [7:0] A_IEN = `UFDR_ADR_IEN;
   localparam logic [7:0] A_IST = `UFDR_ADR_IST;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [3:0] sel_w = 4'hF;
   logic tx_go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [7:0] rval, tx_data;
   logic ack, irq, tx_n, rx_n, tx_valid, tx_ready, tx_empty, rx_valid;
   ufdr_rxchar_s rx_char;
   int err_total = 0;
   int samples_checked = 0;
   int lvl[4] = '{1, 4, 8, 14};

   always #10 clk = ~clk;

   ufdr_top #(.TOUT_CYCLES(TOUT)) ufdr_top_i (
      .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .irq_o(irq), .tx_dma_request_n_o(tx_n), .rx_dma_request_n_o(rx_n),
      .rx_valid_i(rx_valid), .rx_char_i(rx_char), .tx_valid_o(tx_valid),
      .tx_data_o(tx_data), .tx_ready_i(tx_ready),
      .tx_shift_empty_i(tx_empty));

   ufdr_shifter_model ufdr_shifter_model_i (
      .clk_i(clk), .rst_i(rst), .tx_go_i(tx_go), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready),
      .tx_shift_empty_o(tx_empty), .rx_valid_o(rx_valid),
      .rx_char_o(rx_char));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= sel_w;
      adr <= a;
      wdat <= {24'h000000, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rval = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask : bus

   task automatic rdc(string nm, logic [7:0] a, logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, e, rval);
   endtask : rdc

   task automatic step(int n);
      repeat (n) @(posedge clk);
   endtask : step

   task automatic rx(logic [2:0] e, logic [7:0] d);
      ufdr_shifter_model_i.send({e, d});
   endtask : rx

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rdc("line_status", A_LSTAT, 8'h60);
      chk("tx_dma_request_n", 8'h00, 8'(tx_n));
      chk("rx_dma_request_n", 8'h01, 8'(rx_n));
      // A write without its low byte lane selected must be dropped.
      sel_w = 4'hE;
      bus(1'b1, A_IEN, 8'h0F);
      sel_w = 4'hF;
      rdc("int_enable", A_IEN, 8'h00);
      bus(1'b1, A_FCTL, 8'hC8);
      rdc("fifo_control", A_FCTL, 8'h00);
      bus(1'b1, A_FCTL, 8'hFF);
      rdc("fifo_control", A_FCTL, 8'hC9);
   endtask : t_reset

   task automatic t_rx();
      bus(1'b1, A_FCTL, 8'h01);
      bus(1'b1, A_FCTL, 8'h00);
      rx(3'b000, 8'hA5);
      step(1);
      chk("rx_dma_request_n", 8'h00, 8'(rx_n));
      rdc("line_status", A_LSTAT, 8'h61);
      rx(3'b000, 8'h5A);
      rdc("line_status", A_LSTAT, 8'h63);
      rdc("line_status", A_LSTAT, 8'h61);
      rdc("rx_holding_reg", A_DAT, 8'hA5);
      chk("rx_dma_request_n", 8'h01, 8'(rx_n));
      bus(1'b1, A_FCTL, 8'h01);
      rx(3'b001, 8'hC3);
      rdc("line_status", A_LSTAT, 8'hE5);
      chk("irq", 8'h00, 8'(irq));
      rdc("int_status", A_IST, 8'h05);
      bus(1'b1, A_IEN, 8'h04);
      chk("irq", 8'h01, 8'(irq));
      bus(1'b1, A_IST, 8'h0F);
      chk("irq", 8'h00, 8'(irq));
      bus(1'b1, A_FCTL, 8'h03);
      rdc("line_status", A_LSTAT, 8'h60);
   endtask : t_rx

   task automatic t_trig();
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, A_FCTL, {2'(c), 6'h0B});
         bus(1'b1, A_IST, 8'h0F);
         bus(1'b1, A_IEN, 8'h01);
         for (int k = 1; k < lvl[c]; k++) rx(3'b000, 8'(k));
         step(2);
         chk("rx_dma_request_n", 8'h01, 8'(rx_n));
         chk("irq", 8'h00, 8'(irq));
         rx(3'b000, 8'h77);
         step(2);
         chk("rx_dma_request_n", 8'h00, 8'(rx_n));
         chk("irq", 8'h01, 8'(irq));
      end
      rx(3'b000, 8'h01);
      rx(3'b000, 8'h02);
      rdc("line_status", A_LSTAT, 8'h61);
      rx(3'b000, 8'h03);
      rdc("line_status", A_LSTAT, 8'h63);
      bus(1'b1, A_FCTL, 8'hCB);
      step(2);
      chk("rx_dma_request_n", 8'h01, 8'(rx_n));
   endtask : t_trig

   task automatic t_tout();
      bus(1'b1, A_IST, 8'h0F);
      bus(1'b1, A_IEN, 8'h08);
      rx(3'b000, 8'h11);
      step(TOUT / 2);
      chk("rx_dma_request_n", 8'h01, 8'(rx_n));
      chk("irq", 8'h00, 8'(irq));
      step(TOUT);
      chk("rx_dma_request_n", 8'h00, 8'(rx_n));
      chk("irq", 8'h01, 8'(irq));
      rdc("rx_holding_reg", A_DAT, 8'h11);
      step(2);
      chk("rx_dma_request_n", 8'h01, 8'(rx_n));
   endtask : t_tout

   task automatic t_tx();
      bus(1'b1, A_FCTL, 8'h0F);
      bus(1'b1, A_IST, 8'h0F);
      bus(1'b1, A_IEN, 8'h02);
      for (int k = 0; k < 15; k++) bus(1'b1, A_DAT, 8'(k));
      chk("tx_dma_request_n", 8'h00, 8'(tx_n));
      bus(1'b1, A_DAT, 8'hF0);
      chk("tx_dma_request_n", 8'h01, 8'(tx_n));
      rdc("line_status", A_LSTAT, 8'h00);
      bus(1'b1, A_FCTL, 8'h0D);
      rdc("line_status", A_LSTAT, 8'h60);
      bus(1'b1, A_FCTL, 8'h01);
      chk("tx_dma_request_n", 8'h00, 8'(tx_n));
      bus(1'b1, A_DAT, 8'h3C);
      chk("tx_dma_request_n", 8'h01, 8'(tx_n));
      bus(1'b1, A_DAT, 8'hC3);
      tx_go <= 1'b1;
      step(1);
      while (tx_valid === 1'b1) @(posedge clk);
      rdc("line_status", A_LSTAT, 8'h20);
      step(20);
      rdc("line_status", A_LSTAT, 8'h60);
      chk("tx_first", 8'h3C, ufdr_shifter_model_i.got_q[0]);
      chk("tx_second", 8'hC3, ufdr_shifter_model_i.got_q[1]);
      chk("irq", 8'h01, 8'(irq));
   endtask : t_tx

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_rx();
      t_trig();
      t_tout();
      t_tx();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      close_out();
   end
endmodule : ufdr_top_tb
